//--- hdl/cfg_port_pkg.sv
package cfg_port_pkg;
  localparam int CFG_ADDR_W = 10;
  localparam int CFG_DATA_W = 16;
  localparam int NUM_CHAN = 12;
  // Cycles from a taken access to the ready pulse.
  localparam int CFG_LATENCY = 2;
  localparam int CFG_DEPTH = 1024;
  localparam logic [CFG_DATA_W-1:0] CFG_RESET_WORD = 16'h0000;
  // Per-lane widths of the optional test and status ports.
  localparam int PATTERN_SEL_W = 4;
  localparam int BUF_STATUS_W = 3;
  typedef enum logic [1:0] {
    MST_IDLE,
    MST_WAIT
  } mst_state_e;
endpackage

//--- hdl/cfg_port_if.sv
interface cfg_port_if
  import cfg_port_pkg::*;
#(
  parameter int NCH = NUM_CHAN
) (
  input wire logic cfg_port_clock
);
  logic [NCH-1:0] cfg_access_enable;
  logic [NCH-1:0] cfg_write_select;
  logic [NCH-1:0][CFG_ADDR_W-1:0] cfg_address;
  logic [NCH-1:0][CFG_DATA_W-1:0] cfg_write_data;
  logic [NCH-1:0][CFG_DATA_W-1:0] cfg_read_data;
  logic [NCH-1:0] cfg_ready;

  modport device (
    input cfg_port_clock,
    input cfg_access_enable,
    input cfg_write_select,
    input cfg_address,
    input cfg_write_data,
    output cfg_read_data,
    output cfg_ready
  );
  modport master (
    input cfg_port_clock,
    output cfg_access_enable,
    output cfg_write_select,
    output cfg_address,
    output cfg_write_data,
    input cfg_read_data,
    input cfg_ready
  );
endinterface

//--- hdl/cfg_port_device.sv
module cfg_port_device
  import cfg_port_pkg::*;
#(
  parameter int NCH = NUM_CHAN,
  parameter bit EXTRA_PORTS = 1'b0
) (
  cfg_port_if.device cfg_bus,  // Per-channel access ports
  input wire logic srst_in,  // Synchronous reset, active high
  input wire logic [NCH*PATTERN_SEL_W-1:0] rx_test_pattern_select_in,  // Rx
  input wire logic [NCH*PATTERN_SEL_W-1:0] tx_test_pattern_select_in,  // Tx
  output logic [NCH-1:0] rx_test_pattern_error_out,  // Pattern mismatch
  output logic [NCH-1:0] rx_lane_reset_done_out,  // Rx out of reset
  output logic [NCH-1:0] tx_lane_reset_done_out,  // Tx out of reset
  output logic [NCH*BUF_STATUS_W-1:0] rx_elastic_buffer_status_out  // Buffer
);
  // The read-data pipeline taps its second-to-last stage, so it needs two.
  if (NCH < 1) begin : g_bad_nch
    $error("cfg_port_device: at least one channel is needed");
  end
  if (CFG_LATENCY < 2) begin : g_bad_latency
    $error("cfg_port_device: latency must be two cycles or more");
  end
  if (CFG_DEPTH != (1 << CFG_ADDR_W)) begin : g_bad_depth
    $error("cfg_port_device: depth must match the address range");
  end
  if (PATTERN_SEL_W < 1 || BUF_STATUS_W < 1) begin : g_bad_lane_w
    $error("cfg_port_device: lane field widths must be positive");
  end

  // Picks the field of one lane out of a vector packed lane by lane.
  function automatic logic [PATTERN_SEL_W-1:0] lane_sel(
    input logic [NCH*PATTERN_SEL_W-1:0] vec,  // Packed selects
    input int unsigned lane  // Lane number
  );
    return vec[lane*PATTERN_SEL_W +: PATTERN_SEL_W];
  endfunction

  function automatic logic is_write(
    input logic en,  // Access enable
    input logic we  // Write select
  );
    return en && we;
  endfunction

  function automatic logic is_read(
    input logic en,  // Access enable
    input logic we  // Write select
  );
    return en && !we;
  endfunction

  // Shifts one new stage into an answer pipeline.
  function automatic logic [CFG_LATENCY-1:0] shift_in(
    input logic [CFG_LATENCY-1:0] stages,  // Pipeline now
    input logic bit_in  // New stage
  );
    return {stages[CFG_LATENCY-2:0], bit_in};
  endfunction

  // One shared clock; every channel owns its storage and pipeline.
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    logic [CFG_DATA_W-1:0] mem_ff [CFG_DEPTH];
    logic [CFG_LATENCY-1:0] pipe_ff;
    logic [CFG_LATENCY-1:0] rd_pipe_ff;
    logic [CFG_DATA_W-1:0] rdata_ff;
    logic [CFG_DATA_W-1:0] hold_ff;
    logic take;
    logic take_wr;
    logic take_rd;
    logic [CFG_ADDR_W-1:0] addr;
    logic [CFG_DATA_W-1:0] wdata;

    assign take = cfg_bus.cfg_access_enable[c];
    assign take_wr = is_write(take, cfg_bus.cfg_write_select[c]);
    assign take_rd = is_read(take, cfg_bus.cfg_write_select[c]);
    assign addr = cfg_bus.cfg_address[c];
    assign wdata = cfg_bus.cfg_write_data[c];

    // Writes land in the taken cycle with the data of that cycle.
    always_ff @(posedge cfg_bus.cfg_port_clock) begin
      if (take_wr) begin
        mem_ff[addr] <= wdata;
      end
    end

    // The read word is captured when taken and shown with ready.
    always_ff @(posedge cfg_bus.cfg_port_clock) begin
      if (srst_in) begin
        hold_ff <= CFG_RESET_WORD;
      end else if (take_rd) begin
        hold_ff <= mem_ff[addr];
      end
    end

    // Every access, read or write, is answered after the same latency.
    always_ff @(posedge cfg_bus.cfg_port_clock) begin
      if (srst_in) begin
        pipe_ff <= '0;
      end else begin
        pipe_ff <= shift_in(pipe_ff, take);
      end
    end

    // Only reads move the read data, so a write leaves the last answer.
    always_ff @(posedge cfg_bus.cfg_port_clock) begin
      if (srst_in) begin
        rd_pipe_ff <= '0;
      end else begin
        rd_pipe_ff <= shift_in(rd_pipe_ff, take_rd);
      end
    end

    // The answer register loads from the stage before the last, so it moves on the edge that raises ready.
    always_ff @(posedge cfg_bus.cfg_port_clock) begin
      if (srst_in) begin
        rdata_ff <= CFG_RESET_WORD;
      end else if (rd_pipe_ff[CFG_LATENCY-2]) begin
        rdata_ff <= hold_ff;
      end
    end

    assign cfg_bus.cfg_ready[c] = pipe_ff[CFG_LATENCY-1];
    assign cfg_bus.cfg_read_data[c] = rdata_ff;
  end

  // Lanes here are modelled as always healthy; real status comes from
  // the serial lanes, so the ports only report under the option.
  for (genvar l = 0; l < NCH; l++) begin : g_lane
    logic [PATTERN_SEL_W-1:0] rx_sel_ff;
    logic [PATTERN_SEL_W-1:0] tx_sel_ff;
    logic rx_done_ff;
    logic tx_done_ff;
    logic err_ff;
    logic [BUF_STATUS_W-1:0] buf_ff;

    // The selects come from logic on this clock, so need no synchroniser.
    always_ff @(posedge cfg_bus.cfg_port_clock) begin
      if (srst_in) begin
        rx_sel_ff <= '0;
      end else begin
        rx_sel_ff <= lane_sel(rx_test_pattern_select_in, l);
      end
    end

    always_ff @(posedge cfg_bus.cfg_port_clock) begin
      if (srst_in) begin
        tx_sel_ff <= '0;
      end else begin
        tx_sel_ff <= lane_sel(tx_test_pattern_select_in, l);
      end
    end

    // Done rises one cycle after reset, and only with the option.
    always_ff @(posedge cfg_bus.cfg_port_clock) begin
      if (srst_in) begin
        rx_done_ff <= 1'b0;
      end else begin
        rx_done_ff <= EXTRA_PORTS;
      end
    end

    always_ff @(posedge cfg_bus.cfg_port_clock) begin
      if (srst_in) begin
        tx_done_ff <= 1'b0;
      end else begin
        tx_done_ff <= EXTRA_PORTS;
      end
    end

    // A looped healthy lane errs only when its checker waits for a
    // pattern that its sender does not send; select zero means off.
    always_ff @(posedge cfg_bus.cfg_port_clock) begin
      if (srst_in) begin
        err_ff <= 1'b0;
      end else begin
        err_ff <= EXTRA_PORTS && rx_done_ff && (rx_sel_ff != '0) &&
          (rx_sel_ff != tx_sel_ff);
      end
    end

    // The elastic buffer of a healthy lane stays at its nominal level.
    always_ff @(posedge cfg_bus.cfg_port_clock) begin
      if (srst_in) begin
        buf_ff <= '0;
      end else begin
        buf_ff <= '0;
      end
    end

    assign rx_lane_reset_done_out[l] = rx_done_ff;
    assign tx_lane_reset_done_out[l] = tx_done_ff;
    assign rx_test_pattern_error_out[l] = err_ff;
    assign rx_elastic_buffer_status_out[l*BUF_STATUS_W +: BUF_STATUS_W] =
      buf_ff;
  end
endmodule

//--- hdl/cfg_port_master.sv
module cfg_port_master
  import cfg_port_pkg::*;
#(
  parameter int NCH = NUM_CHAN
) (
  cfg_port_if.master cfg_bus,  // Per-channel access ports
  input wire logic srst_in,  // Synchronous reset, active high
  input wire logic [NCH-1:0] req_valid_in,  // Request per channel
  input wire logic [NCH-1:0] req_write_in,  // 1 write, 0 read
  input wire logic [NCH-1:0][CFG_ADDR_W-1:0] req_addr_in,  // Address
  input wire logic [NCH-1:0][CFG_DATA_W-1:0] req_wdata_in,  // Write data
  output logic [NCH-1:0] req_ready_out,  // High when idle; a valid request is taken this cycle
  output logic [NCH-1:0] rsp_valid_out,  // Answer pulse
  output logic [NCH-1:0][CFG_DATA_W-1:0] rsp_rdata_out  // Read answer
);
  if (NCH < 1) begin : g_bad_nch
    $error("cfg_port_master: at least one channel is needed");
  end

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    mst_state_e state_ff;
    logic en_ff;
    logic we_ff;
    logic [CFG_ADDR_W-1:0] addr_ff;
    logic [CFG_DATA_W-1:0] wdata_ff;
    logic rsp_ff;
    logic [CFG_DATA_W-1:0] rdata_ff;
    logic go;

    assign go = (state_ff == MST_IDLE) && req_valid_in[c];
    assign req_ready_out[c] = (state_ff == MST_IDLE);

    always_ff @(posedge cfg_bus.cfg_port_clock) begin
      if (srst_in) begin
        state_ff <= MST_IDLE;
      end else begin
        case (state_ff)
          MST_IDLE: if (go) state_ff <= MST_WAIT;
          MST_WAIT: if (cfg_bus.cfg_ready[c]) state_ff <= MST_IDLE;
          default: state_ff <= MST_IDLE;
        endcase
      end
    end

    // Enable and write select stand for exactly one cycle.
    always_ff @(posedge cfg_bus.cfg_port_clock) begin
      if (srst_in) begin
        en_ff <= 1'b0;
        we_ff <= 1'b0;
      end else begin
        en_ff <= go;
        we_ff <= go && req_write_in[c];
      end
    end

    always_ff @(posedge cfg_bus.cfg_port_clock) begin
      if (srst_in) begin
        addr_ff <= '0;
        wdata_ff <= '0;
      end else if (go) begin
        addr_ff <= req_addr_in[c];
        wdata_ff <= req_wdata_in[c];
      end
    end

    always_ff @(posedge cfg_bus.cfg_port_clock) begin
      if (srst_in) begin
        rsp_ff <= 1'b0;
        rdata_ff <= '0;
      end else begin
        rsp_ff <= (state_ff == MST_WAIT) && cfg_bus.cfg_ready[c];
        if ((state_ff == MST_WAIT) && cfg_bus.cfg_ready[c]) begin
          rdata_ff <= cfg_bus.cfg_read_data[c];
        end
      end
    end

    assign cfg_bus.cfg_access_enable[c] = en_ff;
    assign cfg_bus.cfg_write_select[c] = we_ff;
    assign cfg_bus.cfg_address[c] = addr_ff;
    assign cfg_bus.cfg_write_data[c] = wdata_ff;
    assign rsp_valid_out[c] = rsp_ff;
    assign rsp_rdata_out[c] = rdata_ff;
  end
endmodule

//--- dv/cfg_port_checker.sv
module cfg_port_checker
  import cfg_port_pkg::*;
(
  input wire logic cfg_port_clock,  // Clock
  input wire logic srst_in,  // Reset
  input wire logic [NUM_CHAN-1:0] cfg_access_enable,  // Enable
  input wire logic [NUM_CHAN-1:0] cfg_write_select,  // Write
  input wire logic [NUM_CHAN-1:0][CFG_DATA_W-1:0] cfg_read_data,  // Data
  input wire logic [NUM_CHAN-1:0] cfg_ready  // Ready
);
  default clocking @(posedge cfg_port_clock); endclocking
  default disable iff (srst_in);
  property p_lat; cfg_ready == $past(cfg_access_enable, 2); endproperty
  a_lat: assert property (p_lat) else $error("ready lag");
  property p_rd; cfg_access_enable[0] |-> ##2 cfg_ready[0]; endproperty
  a_rd: assert property (p_rd) else $error("no ready");
  property p_wr;
    cfg_access_enable[0] & cfg_write_select[0] |-> ##2 cfg_ready[0];
  endproperty
  a_wr: assert property (p_wr) else $error("no wr ready");
  property p_once; cfg_access_enable[0] |=> !cfg_access_enable[0]; endproperty
  a_once: assert property (p_once) else $error("long enable");
  property p_we; (cfg_write_select & ~cfg_access_enable) == '0; endproperty
  a_we: assert property (p_we) else $error("stray write");
  property p_gap;
    cfg_access_enable[0] |=> !cfg_access_enable[0] [*3];
  endproperty
  a_gap: assert property (p_gap) else $error("overlap");
  property p_hold; !cfg_ready[0] |-> $stable(cfg_read_data[0]); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_pulse; cfg_ready[0] |=> !cfg_ready[0]; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
endmodule

//--- dv/tb_transceiver_config_port.sv
module tb_transceiver_config_port import cfg_port_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [3:0] ch;
    logic wr;
    logic [9:0] a;
    logic [15:0] d;
  } row_s;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [NUM_CHAN-1:0] req_valid = '0, req_write = '0;
  logic [NUM_CHAN-1:0] req_ready, rsp_valid, err_o, done_o, txd_o;
  logic [NUM_CHAN*BUF_STATUS_W-1:0] buf_o;
  logic [NUM_CHAN-1:0][CFG_ADDR_W-1:0] req_addr = '0;
  logic [NUM_CHAN-1:0][CFG_DATA_W-1:0] req_wdata = '0, rsp_rdata;
  int error_cnt = 0;
  int samples_checked = 0;
  // A read row expects the word named in it; the last rows prove lanes apart.
  row_s rows [8] = '{'{4'h0, 1'b1, 10'h000, 16'ha5a5},
    '{4'h0, 1'b0, 10'h000, 16'ha5a5}, '{4'hb, 1'b1, 10'h3ff, 16'h5a5a},
    '{4'hb, 1'b0, 10'h3ff, 16'h5a5a}, '{4'h0, 1'b1, 10'h3ff, 16'hffff},
    '{4'h0, 1'b0, 10'h3ff, 16'hffff}, '{4'hb, 1'b0, 10'h3ff, 16'h5a5a},
    '{4'h0, 1'b0, 10'h000, 16'ha5a5}};
  always #50 sys_clk_in = ~sys_clk_in;
  cfg_port_if cfg_port_if_inst (.cfg_port_clock(sys_clk_in));
  cfg_port_device cfg_port_device_inst (.cfg_bus(cfg_port_if_inst.device),
    .srst_in(srst_in), .rx_test_pattern_select_in('0),
    .tx_test_pattern_select_in('0), .rx_test_pattern_error_out(err_o),
    .rx_lane_reset_done_out(done_o), .tx_lane_reset_done_out(txd_o),
    .rx_elastic_buffer_status_out(buf_o));
  cfg_port_master cfg_port_master_inst (.cfg_bus(cfg_port_if_inst.master),
    .srst_in(srst_in), .req_valid_in(req_valid), .req_write_in(req_write),
    .req_addr_in(req_addr), .req_wdata_in(req_wdata),
    .req_ready_out(req_ready), .rsp_valid_out(rsp_valid),
    .rsp_rdata_out(rsp_rdata));
  cfg_port_checker cfg_port_checker_inst (.cfg_port_clock(sys_clk_in),
    .srst_in(srst_in),
    .cfg_access_enable(cfg_port_if_inst.cfg_access_enable),
    .cfg_write_select(cfg_port_if_inst.cfg_write_select),
    .cfg_read_data(cfg_port_if_inst.cfg_read_data),
    .cfg_ready(cfg_port_if_inst.cfg_ready));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic xfer(input row_s r);
    int n;
    @(negedge sys_clk_in);
    req_valid[r.ch] = 1'b1;
    req_write[r.ch] = r.wr;
    req_addr[r.ch] = r.a;
    req_wdata[r.ch] = r.d;
    // Ready is looked at mid-cycle; the next rising edge takes the request.
    n = 0;
    while (req_ready[r.ch] !== 1'b1 && n < 20) begin
      @(negedge sys_clk_in);
      n++;
    end
    chk(req_ready[r.ch], 1'b1);
    if (req_ready[r.ch] !== 1'b1) final_report;
    @(negedge sys_clk_in);
    req_valid[r.ch] = 1'b0;
    chk(req_ready[r.ch], 1'b0);
    chk({cfg_port_if_inst.cfg_access_enable[r.ch],
      cfg_port_if_inst.cfg_write_select[r.ch],
      cfg_port_if_inst.cfg_address[r.ch]}, {1'b1, r.wr, r.a});
    chk(cfg_port_if_inst.cfg_write_data[r.ch], r.d);
    repeat (CFG_LATENCY) @(negedge sys_clk_in);
    chk(cfg_port_if_inst.cfg_ready[r.ch], 1'b1);
    if (!r.wr) chk(cfg_port_if_inst.cfg_read_data[r.ch], r.d);
    n = CFG_LATENCY;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (rsp_valid[r.ch] !== 1'b1 && n < 20);
    chk(n, CFG_LATENCY + 1);
    if (!r.wr) chk(rsp_rdata[r.ch], r.d);
    if (rsp_valid[r.ch] !== 1'b1) final_report;
  endtask
  initial begin
    repeat (20) @(negedge sys_clk_in);
    srst_in = 1'b0;
    @(negedge sys_clk_in);
    chk({req_ready, rsp_valid, err_o, done_o}, {12'hfff, 36'h0});
    chk({txd_o, buf_o}, '0);
    foreach (rows[i]) xfer(rows[i]);
    fork
      xfer('{4'h1, 1'b1, 10'h155, 16'h1234});
      xfer('{4'h2, 1'b1, 10'h155, 16'h4321});
    join
    fork
      xfer('{4'h1, 1'b0, 10'h155, 16'h1234});
      xfer('{4'h2, 1'b0, 10'h155, 16'h4321});
    join
    srst_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    srst_in = 1'b0;
    chk(rsp_rdata[0], 16'h0000);
    // Reset leaves the lane memory alone, so the old word must still read.
    xfer('{4'h0, 1'b0, 10'h000, 16'ha5a5});
    final_report;
  end
endmodule
